// >>> hw/disk_gate_pkg.sv
`default_nettype none

package disk_gate_pkg;

  // Clock rates, in nanoseconds as printed, and the divider that makes the servo clock.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SERVO_PERIOD_NS = 200;
  localparam int unsigned SERVO_DIV = SERVO_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PHASE_W = $clog2(SERVO_DIV);

  // Phase points of one servo period: rising edge and falling edge.
  localparam logic [PHASE_W-1:0] PHASE_RISE = 3'h0;
  localparam logic [PHASE_W-1:0] PHASE_FALL = PHASE_W'(SERVO_DIV / 2);

  // Least low time while the clock line changes source: one-half servo period.
  localparam int unsigned HOLD_MIN_CYC = SERVO_DIV / 2 - 1;
  // Longest pause without transitions: two servo periods.
  localparam int unsigned SWITCH_GAP_PERIODS = 2;
  localparam int unsigned SWITCH_GAP_CYC = SWITCH_GAP_PERIODS * SERVO_DIV;

  // Read path figures.
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam int unsigned SYNC_VALID_BYTES = 11;
  localparam int unsigned SYNC_VALID_BITS = SYNC_VALID_BYTES * BITS_PER_BYTE;
  localparam int unsigned LOCK_BITS_DEFAULT = 64;
  localparam int unsigned READ_LAG_BITS = 3;

  // Write path figures, in servo periods or bit times.
  localparam int unsigned SPLICE_MAX_PERIODS = 3;
  localparam int unsigned DRIVER_TURNON_DEFAULT = 2;
  localparam int unsigned ENCODER_DELAY_DEFAULT = 3;
  localparam int unsigned ENCODER_DELAY_MAX = 4;

  // Interface pins that arrive from the controller or the head, sampled together.
  typedef struct packed {
    logic read_gate;
    logic write_gate;
    logic write_clk;
    logic write_data;
    logic media_bit;
  } pins_t;

  localparam pins_t PINS_RESET = '0;

  // Source of the shared servo/read clock line.
  typedef enum logic [1:0] {
    SEL_SERVO,
    SEL_HOLD,
    SEL_RECOVERED
  } clk_sel_t;

endpackage : disk_gate_pkg

`default_nettype wire

// >>> hw/disk_gate_timing.sv
`default_nettype none

module disk_gate_timing #(
  parameter int unsigned LOCK_BITS = disk_gate_pkg::LOCK_BITS_DEFAULT,
  parameter int unsigned TURNON_PERIODS = disk_gate_pkg::DRIVER_TURNON_DEFAULT,
  parameter int unsigned ENC_DELAY = disk_gate_pkg::ENCODER_DELAY_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_read_gate,
  input wire logic i_write_gate,
  input wire logic i_write_clk,
  input wire logic i_write_data,
  input wire logic i_media_bit,
  output logic o_servo_read_clk,
  output logic o_read_data,
  output logic o_read_locked,
  output logic o_write_current,
  output logic o_media_write_data
);

  localparam int unsigned LOCK_W = $clog2(LOCK_BITS + 1);
  localparam int unsigned DRV_W = $clog2(TURNON_PERIODS + ENC_DELAY + 1);
  localparam int LOCK_WAIT_MAX = 704;
  localparam int SERVO_BACK_MAX = 24;
  // Three servo periods from the pin, less the two synchroniser cycles ahead of the counter.
  localparam int SPLICE_MAX_CYC = 22;

  disk_gate_pkg::pins_t pin_s1;
  disk_gate_pkg::pins_t pin_s2;
  disk_gate_pkg::pins_t next_pin_s1;
  logic media_prev;
  logic wclk_prev;
  logic [disk_gate_pkg::PHASE_W-1:0] phase;
  logic [disk_gate_pkg::PHASE_W-1:0] next_phase;

  // Every pin passes two flops; edge detectors only look at the second stage.
  always_comb
  begin
    next_pin_s1 = '{read_gate: i_read_gate, write_gate: i_write_gate, write_clk: i_write_clk,
                    write_data: i_write_data, media_bit: i_media_bit};
    next_phase = phase + 3'h1;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_s1 <= disk_gate_pkg::PINS_RESET;
      pin_s2 <= disk_gate_pkg::PINS_RESET;
      media_prev <= 1'b0;
      wclk_prev <= 1'b0;
      phase <= '0;
    end
    else if (i_ce)
    begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= pin_s1;
      media_prev <= pin_s2.media_bit;
      wclk_prev <= pin_s2.write_clk;
      phase <= next_phase;
    end
  end

  logic servo_tick;
  logic wclk_edge;
  logic read_active;
  assign servo_tick = (phase == disk_gate_pkg::PHASE_RISE);
  assign wclk_edge = pin_s2.write_clk & ~wclk_prev;
  // A read gate that overlaps the record gate is ignored; recording wins.
  assign read_active = pin_s2.read_gate & ~pin_s2.write_gate;

  // Read path: phase capture, lock counting and the three-bit lag line.
  logic [LOCK_W-1:0] bit_cnt;
  logic [LOCK_W-1:0] next_bit_cnt;
  logic [disk_gate_pkg::PHASE_W-1:0] rphase;
  logic [disk_gate_pkg::PHASE_W-1:0] next_rphase;
  logic [disk_gate_pkg::PHASE_W-1:0] rec_phase;
  logic [disk_gate_pkg::READ_LAG_BITS-1:0] lag;
  logic [disk_gate_pkg::READ_LAG_BITS-1:0] next_lag;
  logic next_locked;
  logic next_read_data;
  logic rec_tick;

  assign rec_phase = phase - rphase;
  assign rec_tick = (rec_phase == disk_gate_pkg::PHASE_FALL);

  // The recovered phase tracks media transitions only until lock, then freezes so the clock never jumps.
  always_comb
  begin
    next_bit_cnt = bit_cnt;
    next_rphase = rphase;
    next_locked = o_read_locked;
    next_lag = lag;
    next_read_data = o_read_data;
    if (!read_active)
    begin
      next_bit_cnt = '0;
      next_locked = 1'b0;
    end
    else if (!o_read_locked)
    begin
      if (pin_s2.media_bit != media_prev)
      begin
        next_rphase = phase;
      end
      if (servo_tick)
      begin
        next_bit_cnt = bit_cnt + LOCK_W'(1);
      end
      next_locked = (bit_cnt >= LOCK_W'(LOCK_BITS));
    end
    if (rec_tick)
    begin
      next_lag = {lag[disk_gate_pkg::READ_LAG_BITS-2:0], pin_s2.media_bit};
      next_read_data = o_read_locked & lag[disk_gate_pkg::READ_LAG_BITS-1];
    end
    if (!o_read_locked)
    begin
      next_read_data = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bit_cnt <= '0;
      rphase <= '0;
      lag <= '0;
      o_read_locked <= 1'b0;
      o_read_data <= 1'b0;
    end
    else if (i_ce)
    begin
      bit_cnt <= next_bit_cnt;
      rphase <= next_rphase;
      lag <= next_lag;
      o_read_locked <= next_locked;
      o_read_data <= next_read_data;
    end
  end

  // Clock line source select. A change waits for the falling edge, then holds low at least half a
  // period until the new source rises, trading a short gap for pulses that are never shortened.
  disk_gate_pkg::clk_sel_t sel;
  disk_gate_pkg::clk_sel_t next_sel;
  logic target_rec;
  logic next_target_rec;
  logic [3:0] hold_cnt;
  logic [3:0] next_hold_cnt;
  logic next_clk;
  logic [disk_gate_pkg::PHASE_W-1:0] cur_phase;
  logic [disk_gate_pkg::PHASE_W-1:0] tgt_phase;

  assign cur_phase = (sel == disk_gate_pkg::SEL_RECOVERED) ? rec_phase : phase;
  assign tgt_phase = target_rec ? rec_phase : phase;

  always_comb
  begin
    next_sel = sel;
    next_target_rec = target_rec;
    next_hold_cnt = hold_cnt;
    next_clk = (cur_phase < disk_gate_pkg::PHASE_FALL);
    case (sel)
      disk_gate_pkg::SEL_SERVO:
      begin
        if (o_read_locked && cur_phase == disk_gate_pkg::PHASE_FALL)
        begin
          next_sel = disk_gate_pkg::SEL_HOLD;
          next_target_rec = 1'b1;
          next_hold_cnt = '0;
        end
      end
      disk_gate_pkg::SEL_RECOVERED:
      begin
        if (!o_read_locked && cur_phase == disk_gate_pkg::PHASE_FALL)
        begin
          next_sel = disk_gate_pkg::SEL_HOLD;
          next_target_rec = 1'b0;
          next_hold_cnt = '0;
        end
      end
      disk_gate_pkg::SEL_HOLD:
      begin
        next_clk = 1'b0;
        next_target_rec = o_read_locked;
        if (hold_cnt != 4'hf)
        begin
          next_hold_cnt = hold_cnt + 4'h1;
        end
        if (hold_cnt >= 4'(disk_gate_pkg::HOLD_MIN_CYC) && tgt_phase == disk_gate_pkg::PHASE_RISE)
        begin
          next_sel = target_rec ? disk_gate_pkg::SEL_RECOVERED : disk_gate_pkg::SEL_SERVO;
          next_clk = 1'b1;
        end
      end
      default:
      begin
        next_sel = disk_gate_pkg::SEL_SERVO;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sel <= disk_gate_pkg::SEL_SERVO;
      target_rec <= 1'b0;
      hold_cnt <= '0;
      o_servo_read_clk <= 1'b0;
    end
    else if (i_ce)
    begin
      sel <= next_sel;
      target_rec <= next_target_rec;
      hold_cnt <= next_hold_cnt;
      o_servo_read_clk <= next_clk;
    end
  end

  // Write path: driver turn-on after the gate rises, encoder line clocked by write clock edges.
  // The driver stays on while the encoder line drains so the last bits still reach the medium.
  logic [DRV_W-1:0] drv_cnt;
  logic [DRV_W-1:0] next_drv_cnt;
  logic [ENC_DELAY-1:0] enc;
  logic [ENC_DELAY-1:0] next_enc;
  logic next_wcur;
  logic next_wdata;

  always_comb
  begin
    next_drv_cnt = drv_cnt;
    next_wcur = o_write_current;
    next_enc = enc;
    next_wdata = o_media_write_data;
    if (pin_s2.write_gate != o_write_current)
    begin
      if (servo_tick)
      begin
        next_drv_cnt = drv_cnt + DRV_W'(1);
      end
      if (pin_s2.write_gate && servo_tick && drv_cnt == DRV_W'(TURNON_PERIODS - 1))
      begin
        next_wcur = 1'b1;
        next_drv_cnt = '0;
      end
      if (!pin_s2.write_gate && servo_tick && drv_cnt == DRV_W'(ENC_DELAY - 1))
      begin
        next_wcur = 1'b0;
        next_drv_cnt = '0;
      end
    end
    else
    begin
      next_drv_cnt = '0;
    end
    if (wclk_edge)
    begin
      next_enc = {enc[ENC_DELAY-2:0], pin_s2.write_data};
      next_wdata = enc[ENC_DELAY-1];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      drv_cnt <= '0;
      enc <= '0;
      o_write_current <= 1'b0;
      o_media_write_data <= 1'b0;
    end
    else if (i_ce)
    begin
      drv_cnt <= next_drv_cnt;
      enc <= next_enc;
      o_write_current <= next_wcur;
      o_media_write_data <= next_wdata;
    end
  end

  // Helper counters that only the checks read.
  logic [4:0] run_cnt;
  logic [9:0] lock_wait;
  logic [4:0] splice_wait;
  logic [disk_gate_pkg::ENCODER_DELAY_MAX-1:0] wd_hist;
  logic clk_q;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      run_cnt <= 5'(disk_gate_pkg::HOLD_MIN_CYC); // The low line during reset counts as a full run.
      lock_wait <= '0;
      splice_wait <= '0;
      wd_hist <= '0;
      clk_q <= 1'b0;
    end
    else if (i_ce)
    begin
      clk_q <= o_servo_read_clk;
      run_cnt <= (o_servo_read_clk != clk_q) ? 5'h0 : ((run_cnt == 5'h1f) ? run_cnt : run_cnt + 5'h1);
      lock_wait <= (read_active && !o_read_locked) ? lock_wait + 10'h1 : 10'h0;
      splice_wait <= (pin_s2.write_gate && !o_write_current) ? splice_wait + 5'h1 : 5'h0;
      if (wclk_edge)
      begin
        wd_hist <= {wd_hist[disk_gate_pkg::ENCODER_DELAY_MAX-2:0], pin_s2.write_data};
      end
    end
  end

  property p_lock_in_time;
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    lock_wait <= 10'(LOCK_WAIT_MAX);
  endproperty
  a_lock_in_time: assert property (p_lock_in_time) else $error("Read lock took over 11 bytes.");

  property p_no_short_pulse;
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    (o_servo_read_clk != clk_q) && $past(i_ce) |-> run_cnt >= 5'(disk_gate_pkg::HOLD_MIN_CYC);
  endproperty
  a_no_short_pulse: assert property (p_no_short_pulse) else $error("Clock pulse below half period.");

  property p_gap_bounded;
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    run_cnt < 5'(disk_gate_pkg::SWITCH_GAP_CYC);
  endproperty
  a_gap_bounded: assert property (p_gap_bounded) else $error("Clock line idle over two periods.");

  property p_splice_width;
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    splice_wait <= 5'(SPLICE_MAX_CYC);
  endproperty
  a_splice_width: assert property (p_splice_width) else $error("Write driver late after gate.");

  property p_read_lag;
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    rec_tick && o_read_locked && $past(o_read_locked, 24) |=> o_read_data == $past(pin_s2.media_bit, 25);
  endproperty
  a_read_lag: assert property (p_read_lag) else $error("Read data lag is not three bits.");

  property p_servo_back;
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    $fell(read_active) |-> ##[1:SERVO_BACK_MAX] (sel == disk_gate_pkg::SEL_SERVO);
  endproperty
  a_servo_back: assert property (p_servo_back) else $error("Servo clock not restored in time.");

  property p_encoder_delay;
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    wclk_edge |=> o_media_write_data == $past(wd_hist[ENC_DELAY-1]) && ENC_DELAY <= 4;
  endproperty
  a_encoder_delay: assert property (p_encoder_delay) else $error("Encoder delay out of bound.");

endmodule : disk_gate_timing

`default_nettype wire

// >>> testbench/disk_ctrl_model.sv
`default_nettype none

module disk_ctrl_model
(
  input wire logic i_en,
  input wire logic i_servo_clk,
  input wire logic i_write_gate,
  output logic o_write_clk,
  output logic o_write_data,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 1ps;

  // Byte sync, two data bytes, two check bytes and the pad byte; values are arbitrary test data.
  localparam logic [7:0] TAIL [6] = '{8'ha1, 8'h5a, 8'h3c, 8'h66, 8'hc3, 8'h00};
  int unsigned k;
  int unsigned b;

  // Record clocks are the servo clocks passed through, so they can never drift from the drive.
  assign o_write_clk = i_en & i_servo_clk;

  // Bits change at the servo fall, half a period away from the sampling rise.
  always @(negedge i_servo_clk)
  begin
    if (!i_write_gate)
    begin
      k = 0;
      b = 0;
      o_write_data = 1'b0;
      o_done = 1'b0;
    end
    else if (k < 18)
    begin
      // Twelve zero bytes first, then sync, data, check and pad in that order.
      o_write_data = (k < 12) ? 1'b0 : TAIL[k-12][7-b];
      b = b + 1;
      if (b == 8)
      begin
        b = 0;
        k = k + 1;
      end
    end
    else
    begin
      o_write_data = 1'b0;
      o_done = 1'b1;
    end
  end
endmodule : disk_ctrl_model

`default_nettype wire

// >>> testbench/disk_gate_timing_tb.sv
`default_nettype none

module disk_gate_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_read_gate = 1'b0;
  logic i_write_gate = 1'b0;
  logic i_media_bit = 1'b0;
  logic i_ce = 1'b1;
  logic wr_clk_en = 1'b0;
  logic i_write_clk;
  logic i_write_data;
  logic o_done;
  logic o_servo_read_clk;
  logic o_read_data;
  logic o_read_locked;
  logic o_write_current;
  logic o_media_write_data;
  int n_fail = 0;
  int total_checks = 0;
  int run = 0;
  int bad = 0;
  logic prev = 1'b0;
  logic seen = 1'b0;

  // A short lock count keeps the run brief; the 11 byte bound still applies.
  disk_gate_timing #(.LOCK_BITS(8)) u_disk_gate_timing (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_read_gate(i_read_gate), .i_write_gate(i_write_gate), .i_write_clk(i_write_clk),
    .i_write_data(i_write_data), .i_media_bit(i_media_bit), .o_servo_read_clk(o_servo_read_clk),
    .o_read_data(o_read_data), .o_read_locked(o_read_locked), .o_write_current(o_write_current),
    .o_media_write_data(o_media_write_data));

  disk_ctrl_model u_disk_ctrl_model (.i_en(wr_clk_en), .i_servo_clk(o_servo_read_clk),
    .i_write_gate(i_write_gate), .o_write_clk(i_write_clk), .o_write_data(i_write_data), .o_done(o_done));

  // The clock runs at 40 MHz.
  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end

  // Every high or low run of the shared clock line is measured, except the partial first run after reset and any run that spans a freeze.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      run = 0;
      seen = 1'b0;
    end
    // A frozen line is no clock fault, so the run that spans a freeze is left unmeasured.
    else if (!i_ce)
      seen = 1'b0;
    else if (o_servo_read_clk !== prev)
    begin
      if (seen && (run < 4 || run > 16))
        bad++;
      seen = 1'b1;
      run = 1;
      prev = o_servo_read_clk;
    end
    else
      run++;
  end

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v)
    begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", what, exp_v, seen_v);
    end
  endtask : check

  function automatic logic pick(input int sel);
    case (sel)
      0: return o_read_locked;
      1: return o_read_data;
      2: return o_write_current;
      default: return o_servo_read_clk;
    endcase
  endfunction : pick

  // Waits for a level with a bound; running out of it ends the run as a failure.
  task automatic wait_on(input int sel, input logic lvl, input int bound, output int n);
    n = 0;
    while (pick(sel) !== lvl)
    begin
      @(posedge i_clk);
      #1;
      n++;
      if (n > bound)
      begin
        n_fail++;
        $display("Error wait %0d expected %b seen timeout", sel, lvl);
        conclude();
      end
    end
  endtask : wait_on

  // One medium bit lasts one servo period.
  task automatic put_bit(input logic v);
    @(posedge i_clk);
    i_media_bit <= v;
    repeat (7) @(posedge i_clk);
  endtask : put_bit

  task automatic test_read;
    int n;
    int hi;
    @(posedge i_clk);
    i_read_gate <= 1'b1;
    // Alternating bits give the recovery loop edges to find the bit phase.
    for (int i = 0; i < 12; i++)
    begin
      put_bit(i[0]);
      if (i == 2)
      begin
        #1;
        check("early lock", 32'(o_read_locked), 32'h0);
      end
    end
    for (int i = 0; i < 8; i++)
      put_bit(1'b0);
    // Step off the edge, since the read data register updates on this very edge.
    #1;
    check("locked", 32'(o_read_locked), 32'h1);
    check("read data", 32'(o_read_data), 32'h0);
    @(posedge i_clk);
    i_media_bit <= 1'b1;
    wait_on(1, 1'b1, 48, n);
    check("read lag", 32'(n >= 20 && n <= 34), 32'h1);
    @(posedge i_clk);
    i_read_gate <= 1'b0;
    i_media_bit <= 1'b0;
    wait_on(0, 1'b0, 6, n);
    check("lock drop", 32'(o_read_locked), 32'h0);
    // After the switch window the line must show full servo periods again.
    repeat (26) @(posedge i_clk);
    wait_on(3, 1'b0, 16, n);
    wait_on(3, 1'b1, 16, n);
    wait_on(3, 1'b0, 8, hi);
    wait_on(3, 1'b1, 8, n);
    check("servo period", 32'(hi + n), 32'h8);
    $display("Test read finished");
  endtask : test_read

  task automatic test_write;
    int n;
    int t;
    int t0;
    int t1;
    @(posedge i_clk);
    wr_clk_en <= 1'b1;
    // Clocks lead the gate by over 2.5 periods and the read gate has been low over five periods.
    // Forty cycles leave three periods of margin over a two-period gap in the clock line.
    repeat (40) @(posedge i_clk);
    i_write_gate <= 1'b1;
    wait_on(2, 1'b1, 27, n);
    check("turn on", 32'(n <= 24), 32'h1);
    t = 0;
    t0 = -1;
    t1 = -1;
    while (o_done !== 1'b1 && t < 1300)
    begin
      @(posedge i_clk);
      #1;
      t++;
      if (t0 < 0 && i_write_data === 1'b1)
        t0 = t;
      if (t1 < 0 && o_media_write_data === 1'b1)
        t1 = t;
    end
    check("sector sent", 32'(o_done), 32'h1);
    check("encoder delay", 32'(t0 > 0 && t1 - t0 >= 8 && t1 - t0 <= 32), 32'h1);
    // The gate stays up one more byte so the pad reaches the medium.
    repeat (64) @(posedge i_clk);
    i_write_gate <= 1'b0;
    wait_on(2, 1'b0, 35, n);
    check("turn off", 32'(n <= 35), 32'h1);
    @(posedge i_clk);
    wr_clk_en <= 1'b0;
    // Ten microseconds of quiet also cover the head change margins and the next sector's read delay.
    repeat (400) @(posedge i_clk);
    $display("Test write finished");
  endtask : test_write

  // Dropping the clock enable must freeze the clock line where it stands.
  task automatic test_hold;
    logic held;
    @(posedge i_clk);
    i_ce <= 1'b0;
    @(posedge i_clk);
    #1;
    held = o_servo_read_clk;
    repeat (12) @(posedge i_clk);
    #1;
    check("frozen line", 32'(o_servo_read_clk), 32'(held));
    @(posedge i_clk);
    i_ce <= 1'b1;
    repeat (16) @(posedge i_clk);
    $display("Test hold finished");
  endtask : test_hold

  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    // The read pass verifies the sector ahead of the update, as the controller must.
    test_read();
    test_write();
    test_hold();
    check("clock runs", 32'(bad), 32'h0);
    conclude();
  end
endmodule : disk_gate_timing_tb

`default_nettype wire
